// ### rtl/sira_top.sv
/*
 * Indirect access port: host registers over AXI4-Lite, one fabric
 * access at a time toward the switch register space.
 * Assumes the fabric holds off ack until the access is done and
 * never acks without a pending request.
 */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module sira_top (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address and data
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Fabric side
    output logic                       fab_req_valid,
    output sira_pkg::sira_fab_req_t    fab_req,
    input  wire sira_pkg::sira_fab_rsp_t fab_rsp
);

    typedef enum logic {ST_IDLE, ST_BUSY} sira_state_t;

    sira_state_t          state_ff;          // Busy flag is this state
    logic [31:0]          wr_data_ff;        // Last host-written data
    logic [31:0]          fab_data_ff;       // Last fabric read value
    logic                 rnw_ff;            // Read-not-write select
    logic                 inc_ff;            // Step-up enable
    logic                 dec_ff;            // Step-down enable
    logic [3:0]           lanes_ff;          // Lane write mask
    logic [15:0]          index_ff;          // Target register index
    logic                 op_write_ff;       // Kind of pending access
    sira_pkg::sira_step_t step_ff;           // Step due at completion
    // AXI holding registers
    logic                 aw_got_ff;
    logic                 w_got_ff;
    logic [11:0]          awaddr_ff;
    logic [31:0]          wdata_ff;
    logic [3:0]           wstrb_ff;
    logic                 bvalid_ff;
    logic [1:0]           bresp_ff;
    logic                 rvalid_ff;
    logic [31:0]          rdata_ff;
    logic [1:0]           rresp_ff;

    // Merge write data by byte strobe
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Handshake and decode
    wire busy        = (state_ff == ST_BUSY);
    wire aw_hs       = s_axi_awvalid && s_axi_awready;
    wire w_hs        = s_axi_wvalid && s_axi_wready;
    wire ar_hs       = s_axi_arvalid && s_axi_arready;
    wire do_write    = aw_got_ff && w_got_ff && !bvalid_ff;
    wire wr_is_data  = (awaddr_ff[11:2] == sira_pkg::OFF_DATA[11:2]);
    wire wr_is_cmd   = (awaddr_ff[11:2] == sira_pkg::OFF_CMD[11:2]);
    wire rd_is_data  = (s_axi_araddr[11:2] == sira_pkg::OFF_DATA[11:2]);
    wire rd_is_cmd   = (s_axi_araddr[11:2] == sira_pkg::OFF_CMD[11:2]);
    wire step_en     = inc_ff || dec_ff;
    // Increment has precedence over decrement
    wire sira_pkg::sira_step_t step_dir = inc_ff ? sira_pkg::STEP_UP :
                                          (dec_ff ? sira_pkg::STEP_DOWN
                                                  : sira_pkg::STEP_NONE);

    // Writes are dropped while busy so no register moves mid-access
    wire cmd_wr      = do_write && wr_is_cmd && !busy;
    wire data_wr     = do_write && wr_is_data && !busy;
    wire [31:0] cmd_old = {1'b0, rnw_ff, inc_ff, dec_ff, 8'h00, lanes_ff, index_ff};
    wire [31:0] cmd_new = merge(cmd_old, wdata_ff, wstrb_ff);
    wire go_cmd      = cmd_wr && wstrb_ff[3] && wdata_ff[sira_pkg::BIT_BUSY];
    // Data access launches only with a stepping enable set
    wire go_dwr      = data_wr && step_en;
    wire go_drd      = ar_hs && rd_is_data && step_en && !busy
                       && !go_cmd && !go_dwr;
    wire launch      = go_cmd || go_dwr || go_drd;
    // Direction of the launched access
    wire launch_wr   = go_dwr || (go_cmd && !cmd_new[sira_pkg::BIT_RNW]);
    wire done        = busy && fab_rsp.ack;

    // Index stepped by one in either direction
    function automatic logic [15:0] stepped(input logic [15:0] idx,
                                            input sira_pkg::sira_step_t dir);
        case (dir)
            sira_pkg::STEP_UP:   stepped = idx + sira_pkg::INDEX_STEP;
            sira_pkg::STEP_DOWN: stepped = idx - sira_pkg::INDEX_STEP;
            default:             stepped = idx;
        endcase
    endfunction

    // Next index: command write, read-launch step, or write-done step
    wire [15:0] nxt_index = cmd_wr ? cmd_new[15:0] :
                            go_drd ? stepped(index_ff, step_dir) :
                            (done && op_write_ff) ? stepped(index_ff, step_ff) :
                            index_ff;

    // Read mux: data window shows fabric value only in read mode
    wire [31:0] data_view = rnw_ff ? fab_data_ff : wr_data_ff;
    wire [31:0] rd_mux    = rd_is_data ? data_view :
                            rd_is_cmd  ? {busy, cmd_old[30:0]} : 32'h00000000;

    // AXI ready terms: one item per channel held at a time
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Fabric request from held command fields
    assign fab_req_valid = busy;
    assign fab_req.write = op_write_ff;
    assign fab_req.index = index_ff;
    assign fab_req.wdata = wr_data_ff;
    assign fab_req.lanes = lanes_ff;

    // AXI write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff  <= 32'h00000000;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= sira_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                // Both halves present: commit and answer
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wr_is_data || wr_is_cmd) ? sira_pkg::RESP_OKAY
                                                       : sira_pkg::RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // AXI read channel: data captured at address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= sira_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= (rd_is_data || rd_is_cmd) ? sira_pkg::RESP_OKAY
                                                   : sira_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Command fields and host data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_data_ff <= sira_pkg::DATA_RESET;
            rnw_ff     <= 1'b0;
            inc_ff     <= 1'b0;
            dec_ff     <= 1'b0;
            lanes_ff   <= 4'h0;
            index_ff   <= 16'h0000;
        end else begin
            if (data_wr) begin
                wr_data_ff <= merge(wr_data_ff, wdata_ff, wstrb_ff);
            end
            if (cmd_wr) begin
                rnw_ff   <= cmd_new[sira_pkg::BIT_RNW];
                inc_ff   <= cmd_new[sira_pkg::BIT_INC];
                dec_ff   <= cmd_new[sira_pkg::BIT_DEC];
                lanes_ff <= cmd_new[sira_pkg::LANE_LO +: 4];
            end
            index_ff <= nxt_index;
        end
    end

    // Access sequencer: busy from launch until fabric ack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff    <= ST_IDLE;
            op_write_ff <= 1'b0;
            step_ff     <= sira_pkg::STEP_NONE;
            fab_data_ff <= sira_pkg::DATA_RESET;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (launch) begin
                        state_ff    <= ST_BUSY;
                        op_write_ff <= launch_wr;
                        // Only data-write launches step after completion
                        step_ff     <= go_dwr ? step_dir : sira_pkg::STEP_NONE;
                    end
                end
                default: begin
                    if (fab_rsp.ack) begin
                        // Read value lands in the same edge busy drops
                        if (!op_write_ff) begin
                            fab_data_ff <= fab_rsp.rdata;
                        end
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_launch_sets_busy: assert property (launch |=> busy)
        else $error("launch did not raise busy");
    a_busy_holds_wait: assert property (busy && !fab_rsp.ack |=> busy)
        else $error("busy dropped before ack");
    a_ack_clears_busy: assert property (done |=> !busy && !fab_req_valid)
        else $error("busy stuck after ack");
    a_read_data_load: assert property (done && !op_write_ff
        |=> fab_data_ff == $past(fab_rsp.rdata))
        else $error("read value not loaded at completion");
    // Reset is the antecedent here, so the default disable is switched off
    a_reset_values: assert property (@(posedge aclk) disable iff (1'b0) !aresetn
        |=> !busy && !rnw_ff && !inc_ff && wr_data_ff == sira_pkg::DATA_RESET)
        else $error("reset values wrong");
    a_data_view_mux: assert property (ar_hs && rd_is_data
        |=> rdata_ff == ($past(rnw_ff) ? $past(fab_data_ff) : $past(wr_data_ff)))
        else $error("data read returned wrong source");
    a_step_after_wr: assert property (done && op_write_ff
        && step_ff == sira_pkg::STEP_UP |=> index_ff == $past(index_ff) + 16'h0001)
        else $error("index not stepped after write");
    a_step_on_read: assert property (go_drd && inc_ff
        |=> busy && index_ff == $past(index_ff) + 16'h0001)
        else $error("read launch did not step up");
    a_dec_on_read: assert property (go_drd && !inc_ff
        |=> index_ff == $past(index_ff) - 16'h0001)
        else $error("read launch did not step down");
    // A new request needs a busy write to the command word or a stepping enable
    a_no_plain_launch: assert property ($rose(fab_req_valid)
        |-> $past(do_write && wr_is_cmd && wdata_ff[sira_pkg::BIT_BUSY]) || $past(step_en))
        else $error("access launched without busy write or stepping");
    // A host write during a pending access must leave that access untouched
    a_no_second_op: assert property (busy && !fab_rsp.ack && do_write
        |=> busy && $stable(index_ff) && $stable(rnw_ff) && $stable(wr_data_ff))
        else $error("write while busy changed the pending access");
    a_req_stable: assert property (busy && !fab_rsp.ack |=> $stable(fab_req))
        else $error("request changed while pending");

    c_read_done: cover property (done && !op_write_ff);
    c_inc_write: cover property (go_dwr && inc_ff ##[1:20] done);
    c_dec_read: cover property (go_drd && !inc_ff);

endmodule // sira_top

// ### rtl/sira_pkg.sv
/*
 * Constants and carrier types for the indirect fabric register port.
 * Assumes a 32-bit AXI4-Lite host bus and a fabric that answers each
 * request with a one-cycle acknowledge.
 */
package sira_pkg;
    localparam int unsigned      ADDR_W      = 12;
    localparam logic [11:0]      OFF_DATA    = 12'h1ac;    // Data window
    localparam logic [11:0]      OFF_CMD     = 12'h1b0;    // Command word
    localparam logic [31:0]      DATA_RESET  = 32'h00000000;
    localparam int unsigned      BIT_BUSY    = 31;
    localparam int unsigned      BIT_RNW     = 30;
    localparam int unsigned      BIT_INC     = 29;
    localparam int unsigned      BIT_DEC     = 28;
    localparam int unsigned      LANE_LO     = 16;
    localparam logic [15:0]      INDEX_STEP  = 16'h0001;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;

    // Step applied to the target index
    typedef enum logic [1:0] {STEP_NONE, STEP_UP, STEP_DOWN} sira_step_t;

    // Request toward the fabric register space
    typedef struct packed {
        logic        write;     // 1 = write, 0 = read
        logic [15:0] index;     // Target register index
        logic [31:0] wdata;     // Write value
        logic [3:0]  lanes;     // Byte lanes to update
    } sira_fab_req_t;

    // Answer from the fabric
    typedef struct packed {
        logic        ack;       // One-cycle completion pulse
        logic [31:0] rdata;     // Read value, valid with ack
    } sira_fab_rsp_t;
endpackage

// ### verification/sira_fab_model.sv
/*
 * Behavioural model of the fabric register space behind the indirect port.
 * Assumes request fields hold steady while fab_req_valid is high.
 */
`timescale 1ns/1ps
module sira_fab_model (
    // Clock, reset and pace select
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    slow,
    // Request in, answer out
    input  wire logic                    fab_req_valid,
    input  wire sira_pkg::sira_fab_req_t fab_req,
    output sira_pkg::sira_fab_rsp_t      fab_rsp
);
    logic [31:0] mem [256];  // Only the low index byte is decoded, enough for the bench
    logic [3:0]  wait_ff;    // Cycles spent on the current access

    // Known start pattern so reads before any write are predictable
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'hc0de0000 | i;
    end

    // One access at a time, acked once after a short or a long wait
    always @(posedge aclk) begin
        fab_rsp.ack   <= 1'b0;
        fab_rsp.rdata <= ~fab_rsp.rdata;  // Stale data keeps moving, never looks valid
        if (!aresetn) begin
            wait_ff       <= 4'h0;
            fab_rsp.rdata <= 32'h00000000;
        end else if (fab_req_valid && !fab_rsp.ack) begin
            if (wait_ff < (slow ? 4'h6 : 4'h0)) begin
                wait_ff <= wait_ff + 4'h1;
            end else begin
                wait_ff     <= 4'h0;
                fab_rsp.ack <= 1'b1;
                if (fab_req.write) begin
                    // Unselected bytes keep their old value
                    for (int k = 0; k < 4; k++)
                        if (fab_req.lanes[k]) mem[fab_req.index[7:0]][8*k+:8] <= fab_req.wdata[8*k+:8];
                end else begin
                    fab_rsp.rdata <= mem[fab_req.index[7:0]];
                end
            end
        end
    end
endmodule // sira_fab_model

// ### verification/switch_indirect_reg_access_tb.sv
/*
 * Self-checking bench for the indirect fabric register port.
 * Assumes the fabric model answers both promptly and slowly.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module switch_indirect_reg_access_tb;
    localparam logic [31:0] BSY = 32'h80000000, RNW = 32'h40000000;
    localparam logic [31:0] INC = 32'h20000000, DEC = 32'h10000000, LF = 32'h000f0000;
    localparam logic [11:0] DA = 12'h1ac, CM = 12'h1b0;
    logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, v;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, fvalid, last_v = 1'b0;
    logic [1:0]  bresp, rresp, r;
    int          n_fail = 0, checks = 0, launches = 0, n0;
    sira_pkg::sira_fab_req_t freq;
    sira_pkg::sira_fab_rsp_t frsp;
    typedef struct { logic [15:0] idx; logic [31:0] d; logic [3:0] ln; logic [31:0] exp; } row_t;
    row_t rows [4] = '{'{16'h0001, 32'h11223344, 4'hf, 32'h11223344},
                       '{16'h0002, 32'haabbccdd, 4'h1, 32'hc0de00dd},
                       '{16'h0003, 32'h55667788, 4'h6, 32'hc0667703},
                       '{16'h0004, 32'h9abcdef0, 4'h8, 32'h9ade0004}};

    always #10 aclk = ~aclk;  // 50 MHz
    // Count fabric launches from the rising edge of the request
    always @(posedge aclk) begin
        last_v <= fvalid;
        if (fvalid && !last_v) launches++;
    end

    sira_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fab_req_valid(fvalid), .fab_req(freq), .fab_rsp(frsp));
    sira_fab_model i_fab (.aclk(aclk), .aresetn(aresetn), .slow(slow),
        .fab_req_valid(fvalid), .fab_req(freq), .fab_rsp(frsp));

    // AXI4-Lite write: address and data together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin r = bresp; bready <= 1'b0; break; end
        end
    endtask
    // AXI4-Lite read, rready held until the answer
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
        end
    endtask
    // Poll the command word until the pending flag drops
    task automatic idle();
        for (int i = 0; i < 40; i++) begin rd(CM, v); if (v[31] === 1'b0) break; end
        `CHK(v[31], 1'b0)
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(DA, v); `CHK(v, 32'h00000000)
        rd(CM, v); `CHK(v, 32'h00000000)
        // Table: write through lanes, read back through the data window
        foreach (rows[i]) begin
            slow <= i[0];
            wr(DA, rows[i].d);
            wr(CM, BSY | {12'h0, rows[i].ln, rows[i].idx});
            idle();
            wr(CM, BSY | RNW | LF | rows[i].idx);
            idle();
            rd(DA, v); `CHK(v, rows[i].exp)
        end
        // Pending flag visible during a slow access; overlapping commands dropped
        slow <= 1'b1;
        n0 = launches;
        wr(CM, BSY | RNW | LF | 16'h0005);
        rd(CM, v); `CHK(v[31], 1'b1)
        wr(CM, BSY | LF | 16'h0009);
        idle();
        `CHK(v[15:0], 16'h0005)
        `CHK(launches - n0, 1)
        // Rows of direction data: written value shown while direction is write
        wr(CM, LF | 16'h0006);
        n0 = launches;
        wr(DA, 32'h01020304);
        rd(DA, v); `CHK(v, 32'h01020304)
        repeat (10) @(posedge aclk);
        `CHK(launches - n0, 0)
        // Stepping writes: up, down, and both enables set
        slow <= 1'b0;
        wr(CM, INC | LF | 16'h0010); wr(DA, 32'hdeadbeef); idle();
        `CHK(v[15:0], 16'h0011)
        wr(CM, DEC | LF | 16'h0020); wr(DA, 32'h0000abcd); idle();
        `CHK(v[15:0], 16'h001f)
        wr(CM, INC | DEC | LF | 16'h0030); wr(DA, 32'h12345678); idle();
        `CHK(v[15:0], 16'h0031)
        // Stepping read chain: read fires the next access, stepping cleared before last read
        wr(CM, BSY | RNW | INC | LF | 16'h0010); idle();
        n0 = launches;
        rd(DA, v); `CHK(v, 32'hdeadbeef)
        idle();
        `CHK(v[15:0], 16'h0011)
        `CHK(launches - n0, 1)
        wr(CM, RNW | LF | 16'h0011);
        rd(DA, v); `CHK(v, 32'hc0de0011)
        repeat (4) @(posedge aclk);
        `CHK(launches - n0, 1)
        // The step-down write went to the index before stepping
        wr(CM, BSY | RNW | LF | 16'h0020); idle();
        rd(DA, v); `CHK(v, 32'h0000abcd)
        // Unmapped address answers with an error on both channels
        wr(12'h100, 32'hffffffff); `CHK(r, sira_pkg::RESP_SLVERR)
        rd(12'h100, v); `CHK(r, sira_pkg::RESP_SLVERR)
        `CHK(v, 32'h00000000)
        // Reset in mid-access: pending flag, stepping and data return to zero
        slow <= 1'b1;
        wr(DA, 32'h5a5a5a5a);
        wr(CM, BSY | RNW | INC | LF | 16'h0007);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        n0 = launches;
        rd(DA, v); `CHK(v, 32'h00000000)
        rd(CM, v); `CHK(v, 32'h00000000)
        repeat (4) @(posedge aclk);
        `CHK(launches - n0, 0)
        wrap_up();
    end
endmodule // switch_indirect_reg_access_tb
